// ===== sim/sdl_host_model.sv
// Host serial port model driving the loader pins
`timescale 1ns/100ps
module sdl_host_model (
   input wire logic mclk_i,
   output logic frame_n_o,
   output logic sclk_o,
   output logic serial_data_in_o,
   output logic load_latch_n_o
);
   localparam int HALF_SCLK = 8;
   initial begin
      frame_n_o = 1'b1;
      sclk_o = 1'b1;
      serial_data_in_o = 1'b0;
      load_latch_n_o = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   // frame low, bit set before fall
   task automatic send_word(input logic [15:0] w, input int n_bits);
      frame_n_o = 1'b0;
      for (int i = 15; i > 15 - n_bits; i--) begin
         serial_data_in_o = w[i];
         wait_clk(HALF_SCLK);
         sclk_o = 1'b0;
         wait_clk(HALF_SCLK);
         sclk_o = 1'b1;
      end
      wait_clk(HALF_SCLK);
      frame_n_o = 1'b1;
      serial_data_in_o = ~serial_data_in_o;
      // Frame must be seen high before the next word
      wait_clk(HALF_SCLK);
   endtask
   // Clock edges outside a frame, random data
   task automatic stray_clocks(input int n);
      repeat (n) begin
         serial_data_in_o = 1'($urandom);
         wait_clk(HALF_SCLK);
         sclk_o = 1'b0;
         wait_clk(HALF_SCLK);
         sclk_o = 1'b1;
      end
   endtask
   task automatic strobe();
      load_latch_n_o = 1'b0;
      wait_clk(4);
      load_latch_n_o = 1'b1;
      wait_clk(4);
   endtask
   task automatic set_auto(input logic on);
      load_latch_n_o = ~on;
      wait_clk(4);
   endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench of the serial DAC input loader
`timescale 1ns/100ps
module testbench;
   logic mclk;
   logic rst_n;
   logic frame_n, sclk, sdata, load_n;
   logic [11:0] dac_code;
   logic signed [11:0] dac_value;
   logic c_zero, c_neg, c_pos, upd, word_ready;
   logic [11:0] exp_q[$];
   logic [15:0] w;
   logic [11:0] last;
   logic [11:0] exp_code;
   int n_errors;
   int samples_checked;
   sdl_pkg::sdl_latch_s seen, expv;
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   sdl_host_model i_host (.mclk_i(mclk), .frame_n_o(frame_n),
      .sclk_o(sclk), .serial_data_in_o(sdata), .load_latch_n_o(load_n));
   sdl_loader i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .frame_n_i(frame_n),
      .sclk_i(sclk), .serial_data_in_i(sdata), .load_latch_n_i(load_n),
      .dac_code_o(dac_code), .dac_value_o(dac_value), .code_zero_o(c_zero),
      .code_neg_fs_o(c_neg), .code_pos_fs_o(c_pos), .latch_update_o(upd),
      .word_ready_o(word_ready));
   task automatic fail(input string what, input logic [14:0] e,
         input logic [14:0] s);
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****************************************************************
   // Result watcher
   // ****************************************************************
   always @(negedge mclk) begin
      if (upd === 1'b1) begin
         samples_checked++;
         seen = {dac_code, c_neg, c_pos, c_zero};
         if (exp_q.size() == 0) begin
            fail("unexpected update", 15'h0, seen);
         end else begin
            exp_code = exp_q.pop_front();
            expv = {exp_code, exp_code == sdl_pkg::CODE_NEG_FS,
               exp_code == sdl_pkg::CODE_POS_FS,
               exp_code == sdl_pkg::CODE_ZERO};
            if (seen !== expv) fail("latch", expv, seen);
            if (dac_value !== exp_code) begin
               fail("value", exp_code, dac_value);
            end
         end
      end
   end
   initial begin
      #100us;
      n_errors++;
      summarize();
   end
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      n_errors = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      void'($urandom(32'h3644));
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) begin
         w = 16'($urandom);
         exp_q.push_back(w[11:0]); // low bits only
         i_host.send_word(w, 16);
         samples_checked++;
         if (word_ready !== 1'b1) fail("word_ready", 15'h1, word_ready);
         i_host.strobe();
      end
      $display("test strobed done");
      exp_q.push_back(w[11:0]);
      i_host.stray_clocks(6); // frame high ignored
      i_host.strobe();
      $display("test stray clocks done");
      exp_q.push_back(w[11:0]); // strobe fall reloads
      i_host.set_auto(1'b1);
      for (int i = 0; i < 4; i++) begin
         last = (i == 0) ? 12'h000 : (i == 1) ? 12'h800 :
            (i == 2) ? 12'h7ff : 12'($urandom);
         w = {4'($urandom), last};
         exp_q.push_back(last);
         i_host.send_word(w, 16);
      end
      $display("test auto boundary done");
      w = 16'($urandom);
      i_host.send_word(16'($urandom), 5);
      samples_checked++;
      if (word_ready !== 1'b0) fail("word_ready", 15'h0, word_ready);
      exp_q.push_back(w[11:0]);
      i_host.send_word(w, 16); // counter restarts
      i_host.wait_clk(10);
      $display("test partial frame done");
      samples_checked++;
      if (exp_q.size() != 0) begin
         fail("missing updates", 15'h0, 15'(exp_q.size()));
      end
      summarize();
   end
endmodule

// ===== verilog/sdl_loader.sv
// Serial input shift register and DAC latch control
// Notes on behaviour
// RL1: Sample data on falling clock while frame low (code samples only the first 16 falling edges after frame falls)
// RL2: Load strobe falling edge copies low 12 bits
// RL3: Strobe held low: auto load after sixteen
// RL4: Latch code is two's complement bipolar
// RL5: All-zero code is bipolar zero midpoint
// RL6: 0x800 negative, 0x7ff positive full scale
// RL7: Host keeps serial rate within limit
// RL8: Frame going low clears bit counter
// RL9: Auto on 16th edge, strobed on edge
// RL10: First four bits shifted are discarded
`timescale 1ns/100ps
module sdl_loader #(
   parameter int WORD_BITS = sdl_pkg::WORD_BITS,
   parameter int CODE_BITS = sdl_pkg::CODE_BITS
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic frame_n_i,
   input wire logic sclk_i,
   input wire logic serial_data_in_i,
   input wire logic load_latch_n_i,
   output logic [CODE_BITS-1:0] dac_code_o,
   output logic signed [CODE_BITS-1:0] dac_value_o,
   output logic code_zero_o,
   output logic code_neg_fs_o,
   output logic code_pos_fs_o,
   output logic latch_update_o,
   output logic word_ready_o
);
   // ****************************************************************
   // Pin synchronisation
   // ****************************************************************
   sdl_pkg::sdl_pins_s pins_raw;
   sdl_pkg::sdl_pins_s pins;

   assign pins_raw = '{frame_n: frame_n_i, sclk: sclk_i,
                       data: serial_data_in_i, load_n: load_latch_n_i};

   sdl_sync #(.WIDTH(4)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(pins_raw),
      .sync_o(pins)
   );

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   typedef enum logic [1:0] {
      SDL_IDLE = 2'b00,
      SDL_SHIFT = 2'b01,
      SDL_FULL = 2'b10
   } sdl_state_e;

   sdl_state_e state_r;
   sdl_state_e state_nxt;
   logic sclk_d_r;
   logic sclk_d_nxt;
   logic frame_d_r;
   logic frame_d_nxt;
   logic load_d_r;
   logic load_d_nxt;
   logic [WORD_BITS-1:0] shift_r;
   logic [WORD_BITS-1:0] shift_nxt;
   logic [sdl_pkg::CNT_BITS-1:0] cnt_r;
   logic [sdl_pkg::CNT_BITS-1:0] cnt_nxt;
   sdl_pkg::sdl_latch_s latch_r;
   sdl_pkg::sdl_latch_s latch_nxt;
   logic update_r;
   logic update_nxt;
   logic sclk_fall;
   logic frame_fall;
   logic load_fall;
   logic [CODE_BITS-1:0] new_code;
   logic do_load;

   assign sclk_fall = sclk_d_r & ~pins.sclk;
   assign frame_fall = frame_d_r & ~pins.frame_n;
   assign load_fall = load_d_r & ~pins.load_n;

   // ****************************************************************
   // Shift and latch
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      latch_nxt = latch_r;
      update_nxt = 1'b0;
      sclk_d_nxt = pins.sclk;
      frame_d_nxt = pins.frame_n;
      load_d_nxt = pins.load_n;
      do_load = 1'b0;
      new_code = shift_r[CODE_BITS-1:0];
      // RL8: frame low restarts count
      if (frame_fall) begin
         cnt_nxt = '0;
         state_nxt = SDL_SHIFT;
      end
      // RL1: sample on falling clock edge
      if (!pins.frame_n && sclk_fall && (state_r == SDL_SHIFT ||
          frame_fall)) begin
         shift_nxt = {shift_r[WORD_BITS-2:0], pins.data};
         cnt_nxt = (frame_fall ? 5'h00 : cnt_r) + 5'h01;
         new_code = shift_nxt[CODE_BITS-1:0];
         if (cnt_nxt == sdl_pkg::WORD_COUNT) begin
            state_nxt = SDL_FULL;
            // RL3: auto load when strobe held low
            // RL9: on sixteenth falling edge
            if (!pins.load_n && !load_fall) begin
               do_load = 1'b1;
            end
         end
      end
      // RL2: strobe falling edge loads latch
      // RL9: strobed update at strobe edge
      if (load_fall) begin
         do_load = 1'b1;
      end
      if (do_load) begin
         // RL10: upper four bits dropped
         latch_nxt.code = new_code;
         // RL5: zero code is midpoint
         latch_nxt.zero = (new_code == sdl_pkg::CODE_ZERO);
         // RL6: full scale codes
         latch_nxt.neg_fs = (new_code == sdl_pkg::CODE_NEG_FS);
         latch_nxt.pos_fs = (new_code == sdl_pkg::CODE_POS_FS);
         update_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_r <= SDL_IDLE;
         shift_r <= '0;
         cnt_r <= '0;
         latch_r <= '{code: sdl_pkg::CODE_RESET, neg_fs: 1'b0,
                      pos_fs: 1'b0, zero: 1'b1};
         update_r <= 1'b0;
         sclk_d_r <= 1'b1;
         frame_d_r <= 1'b1;
         load_d_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         latch_r <= latch_nxt;
         update_r <= update_nxt;
         sclk_d_r <= sclk_d_nxt;
         frame_d_r <= frame_d_nxt;
         load_d_r <= load_d_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic word_ready_r;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         word_ready_r <= 1'b0;
      end else begin
         word_ready_r <= (state_nxt == SDL_FULL);
      end
   end

   assign dac_code_o = latch_r.code;
   // RL4: code read as two's complement
   assign dac_value_o = $signed(latch_r.code);
   assign code_zero_o = latch_r.zero;
   assign code_neg_fs_o = latch_r.neg_fs;
   assign code_pos_fs_o = latch_r.pos_fs;
   assign latch_update_o = update_r;
   assign word_ready_o = word_ready_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_auto_word;
      !pins.load_n && !load_fall && sclk_fall && !pins.frame_n &&
      !frame_fall && state_r == SDL_SHIFT && cnt_r == 5'h0f;
   endsequence

   a_auto_load: assert property ( // RL3
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_auto_word |=> latch_update_o &&
         dac_code_o == $past(shift_nxt[CODE_BITS-1:0]))
      else $error("auto load missed");

   a_strobe_load: assert property ( // RL2
      @(posedge mclk_i) disable iff (!rst_n_i)
      load_fall |=> latch_update_o)
      else $error("strobe load missed");

   a_no_spurious: assert property ( // RL9
      @(posedge mclk_i) disable iff (!rst_n_i)
      latch_update_o |-> $past(load_fall) || $past(sclk_fall))
      else $error("update without cause");

   a_latch_hold: assert property ( // RL9
      @(posedge mclk_i) disable iff (!rst_n_i)
      !latch_update_o |-> $stable(dac_code_o))
      else $error("latch changed without update");

   a_shift_bit: assert property ( // RL1
      @(posedge mclk_i) disable iff (!rst_n_i)
      (sclk_fall && !pins.frame_n && state_r == SDL_SHIFT) |=>
         shift_r[0] == $past(pins.data))
      else $error("bit not captured");

   a_frame_clear: assert property ( // RL8
      @(posedge mclk_i) disable iff (!rst_n_i)
      (frame_fall && !sclk_fall) |=> cnt_r == 5'h00)
      else $error("counter not cleared");

   a_zero_flag: assert property ( // RL5
      @(posedge mclk_i) disable iff (!rst_n_i)
      code_zero_o == (dac_code_o == 12'h000))
      else $error("zero flag wrong");

   a_fs_flags: assert property ( // RL6
      @(posedge mclk_i) disable iff (!rst_n_i)
      code_neg_fs_o == (dac_code_o == 12'h800) &&
      code_pos_fs_o == (dac_code_o == 12'h7ff))
      else $error("full scale flag wrong");

   a_signed_val: assert property ( // RL4
      @(posedge mclk_i) disable iff (!rst_n_i)
      dac_value_o[CODE_BITS-1] == dac_code_o[CODE_BITS-1] &&
      (!code_neg_fs_o || dac_value_o < 0) &&
      (!code_pos_fs_o || dac_value_o > 0))
      else $error("sign wrong");
endmodule

// ===== verilog/sdl_pkg.sv
// Package: constants and carrier types of the serial DAC input loader
package sdl_pkg;
   // ****************************************************************
   // Widths and counts
   // ****************************************************************
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] WORD_COUNT = 5'h10;
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [11:0] CODE_NEG_FS = 12'h800;
   localparam logic [11:0] CODE_POS_FS = 12'h7ff;
   localparam logic [11:0] CODE_ZERO = 12'h000;
   localparam int SYNC_STAGES = 2;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic frame_n;
      logic sclk;
      logic data;
      logic load_n;
   } sdl_pins_s;

   typedef struct packed {
      logic [11:0] code;
      logic neg_fs;
      logic pos_fs;
      logic zero;
   } sdl_latch_s;
endpackage

// ===== verilog/sdl_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module sdl_sync #(
   parameter int WIDTH = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end

   // Idle pins high except data; reset value all ones is safe
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta_r <= '1;
         sync_r <= '1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_o = sync_r;
endmodule
